// ===== src/arml_crc_byte.sv
// one byte step of the message crc
`timescale 1ns/100ps
module arml_crc_byte
(
   input  wire  logic [15:0] crc_in,
   input  wire  logic [7:0]  data,
   output logic       [15:0] crc_out
);
   import arml_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // shift the byte into the low end msb first, fold the bit pushed out of the top
   always_comb
   begin
      logic fb;
      fb      = 1'b0;
      crc_out = crc_in;
      for (int i = 7; i >= 0; i--)
      begin
         fb      = crc_out[15];
         crc_out = {crc_out[14:0], data[i]} ^ (fb ? CRC_GENERATOR_POLYNOMIAL : 16'h0000);
      end
   end

endmodule // arml_crc_byte

// ===== src/arml_link.sv
// acknowledged, retransmitting message link of the host port
`timescale 1ns/100ps
module arml_link
#(
   parameter int          DEPTH       = arml_pkg::QUEUE_DEPTH,
   parameter logic [31:0] ACK_TIMEOUT = 32'(arml_pkg::ACK_TIMEOUT_CYC)
)
(
   input  wire  logic                 clk,
   input  wire  logic                 resetn,
   input  wire  arml_pkg::arml_byte_t rx,
   output arml_pkg::arml_byte_t       tx,
   input  wire  logic                 tx_ready,
   input  wire  arml_pkg::arml_byte_t msg,
   output logic                       msg_ready,
   output logic                       cmd_mode,
   output logic                       ack_retransmit_protocol,
   output logic                       ack_wait
);
   import arml_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || ACK_TIMEOUT < 1)
   begin : g_chk
      $error("arml_link: DEPTH must be a power of two >= 2, ACK_TIMEOUT >= 1");
   end

   // hex character to nibble, bit 4 marks a valid digit
   function automatic logic [4:0] hex2n(input logic [7:0] c);
      if (c >= CH_ZERO && c <= 8'h39) return {1'b1, 4'(c - CH_ZERO)};
      if (c >= CH_A && c <= 8'h46)    return {1'b1, 4'(c - CH_A + 8'h0A)};
      if (c >= CH_LA && c <= 8'h66)   return {1'b1, 4'(c - CH_LA + 8'h0A)};
      return 5'h00;
   endfunction

   function automatic logic [7:0] n2hex(input logic [3:0] n);
      return (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_A + {4'h0, n} - 8'h0A;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // receive parser state
   logic                      rx_act_q,  rx_act_d;
   logic [RX_MAX-1:0][7:0]    rx_buf_q,  rx_buf_d;
   logic [3:0]                rx_len_q,  rx_len_d;
   logic [3:0][7:0]           dl_q,      dl_d;
   logic [2:0]                dl_cnt_q,  dl_cnt_d;
   logic [15:0]               rx_crc_q,  rx_crc_d;
   logic [15:0]               rx_crc_nx;

   // crc lags four bytes so the crc field itself is never folded in
   arml_crc_byte u_rx_crc (.crc_in(rx_crc_q), .data(dl_q[3]), .crc_out(rx_crc_nx));

   always_comb
   begin
      rx_act_d = rx_act_q;
      rx_buf_d = rx_buf_q;
      rx_len_d = rx_len_q;
      dl_d     = dl_q;
      dl_cnt_d = dl_cnt_q;
      rx_crc_d = rx_crc_q;
      if (rx.valid && rx.data == CH_SOM)
      begin
         rx_act_d = 1'b1;
         rx_len_d = 4'h0;
         rx_crc_d = CRC_INIT;
         dl_d[0]  = CH_SOM;
         dl_cnt_d = 3'h1;
      end
      else if (rx.valid && rx_act_q && rx.data == CH_EOM)
         rx_act_d = 1'b0;
      else if (rx.valid && rx_act_q)
      begin
         if (rx_len_q == 4'(RX_MAX))
            rx_act_d = 1'b0;                                      // too long, dropped
         else
         begin
            rx_buf_d[rx_len_q] = rx.data;
            rx_len_d           = rx_len_q + 4'h1;
         end
         if (dl_cnt_q == 3'h4)
            rx_crc_d = rx_crc_nx;
         else
            dl_cnt_d = dl_cnt_q + 3'h1;
         dl_d = {dl_q[2:0], rx.data};
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_act_q <= 1'b0;
         rx_buf_q <= '0;
         rx_len_q <= 4'h0;
         dl_q     <= '0;
         dl_cnt_q <= 3'h0;
         rx_crc_q <= CRC_INIT;
      end
      else
      begin
         rx_act_q <= rx_act_d;
         rx_buf_q <= rx_buf_d;
         rx_len_q <= rx_len_d;
         dl_q     <= dl_d;
         dl_cnt_q <= dl_cnt_d;
         rx_crc_q <= rx_crc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame decode at end of message
   logic       rx_eom, wild, crc_ok, frame_ok, ack_hit;
   logic [3:0] blen;
   logic [7:0] b0, b1, b2;
   logic [4:0] h3, h2, h1, h0;
   logic       is_ack, c00, c01, c610, c611;
   logic [3:0] seq_q, seq_d;
   logic       wait_q, wait_d;

   assign rx_eom   = rx.valid && rx_act_q && rx.data == CH_EOM;
   assign wild     = dl_q == {4{CH_WILD}};
   assign h3       = hex2n(dl_q[3]);
   assign h2       = hex2n(dl_q[2]);
   assign h1       = hex2n(dl_q[1]);
   assign h0       = hex2n(dl_q[0]);
   assign crc_ok   = wild || (h3[4] && h2[4] && h1[4] && h0[4]
                     && {h3[3:0], h2[3:0], h1[3:0], h0[3:0]} == rx_crc_q);
   assign frame_ok = rx_eom && (ack_retransmit_protocol ? (rx_len_q >= 4'h6 && crc_ok)
                                                        : rx_len_q >= 4'h1);
   assign blen     = ack_retransmit_protocol ? rx_len_q - 4'h5 : rx_len_q;
   assign b0       = ack_retransmit_protocol ? rx_buf_q[1] : rx_buf_q[0];
   assign b1       = ack_retransmit_protocol ? rx_buf_q[2] : rx_buf_q[1];
   assign b2       = ack_retransmit_protocol ? rx_buf_q[3] : rx_buf_q[2];
   assign is_ack   = frame_ok && ack_retransmit_protocol && blen == 4'h1 && b0 == CH_ACK;
   assign ack_hit  = is_ack && wait_q && rx_buf_q[0] == CH_ZERO + {4'h0, seq_q};
   assign c01      = frame_ok && blen == 4'h2 && b0 == CH_ZERO && b1 == CH_ONE;
   assign c00      = frame_ok && cmd_mode && blen == 4'h2 && b0 == CH_ZERO && b1 == CH_ZERO;
   assign c610     = frame_ok && cmd_mode && blen == 4'h3 && b0 == CH_SIX && b1 == CH_ONE
                     && b2 == CH_ZERO;
   assign c611     = frame_ok && cmd_mode && blen == 4'h3 && b0 == CH_SIX && b1 == CH_ONE
                     && b2 == CH_ONE;

   ////////////////////////////////////////////////////////////////////////////
   // queue, protocol control and transmitter state
   logic [7:0]          q_mem_q [DEPTH];
   logic [7:0]          q_mem_d [DEPTH];
   logic [PW-1:0]       wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0]       cnt_q, cnt_d;
   logic [31:0]         tmr_q, tmr_d;
   logic                resp_q, resp_d, cmd_q, cmd_d, proto_q, proto_d;
   logic [7:0]          rseq_q, rseq_d;
   arml_tx_state_t      st_q, st_d;
   logic [5:0][7:0]     tb_q, tb_d;
   logic [2:0]          idx_q, idx_d, tlen_q, tlen_d;
   logic [15:0]         tcrc_q, tcrc_d, tcrc_nx;
   arml_byte_t          tx_q, tx_d;
   logic                mrdy_q, mrdy_d, push, pop, start_msg, start_resp, hs;
   logic [7:0]          seqc;

   arml_crc_byte u_tx_crc (.crc_in(tcrc_q), .data(tx_q.data), .crc_out(tcrc_nx));

   assign hs         = tx_q.valid && tx_ready;
   assign push       = msg.valid && mrdy_q;
   assign seqc       = CH_ZERO + {4'h0, seq_q};
   assign start_resp = st_q == TX_IDLE && resp_q && !rx_eom;
   assign start_msg  = st_q == TX_IDLE && !resp_q && !rx_eom && !cmd_q && cnt_q != '0
                       && (!wait_q || tmr_q == ACK_TIMEOUT);
   assign pop        = ack_hit || (start_msg && !proto_q);

   always_comb
   begin
      q_mem_d = q_mem_q;
      wr_d    = wr_q;
      rd_d    = rd_q;
      cnt_d   = cnt_q;
      seq_d   = seq_q;
      wait_d  = wait_q;
      tmr_d   = tmr_q;
      resp_d  = resp_q;
      rseq_d  = rseq_q;
      cmd_d   = cmd_q;
      proto_d = proto_q;
      st_d    = st_q;
      tb_d    = tb_q;
      idx_d   = idx_q;
      tlen_d  = tlen_q;
      tcrc_d  = tcrc_q;
      // hold new messages while one is unanswered
      if (push)
      begin
         q_mem_d[wr_q] = msg.data;
         wr_d          = wr_q + PW'(1);
      end
      if (pop)
         rd_d = rd_q + PW'(1);
      cnt_d = cnt_q + CW'(push) - CW'(pop);
      // acknowledgement and timer
      if (ack_hit)
      begin
         wait_d = 1'b0;
         seq_d  = (seq_q == 4'(SEQ_MOD - 1)) ? 4'h0 : seq_q + 4'h1;
      end
      else if (start_msg && proto_q)
      begin
         wait_d = 1'b1;
         tmr_d  = 32'h0;
      end
      else if (wait_q && tmr_q != ACK_TIMEOUT)
         tmr_d = tmr_q + 32'h1;
      // commands answered with Done
      if (c01 || c00 || c610 || c611)
      begin
         resp_d = 1'b1;
         rseq_d = rx_buf_q[0];
      end
      else if (start_resp)
         resp_d = 1'b0;
      if (c01)
         cmd_d = 1'b1;
      if (c00)
         cmd_d = 1'b0;
      if (c610)
      begin
         proto_d = 1'b0;
         wait_d  = 1'b0;
      end
      if (c611)
         proto_d = 1'b1;
      // frame sequencer
      tcrc_d = (st_q == TX_HEAD && hs) ? tcrc_nx : tcrc_q;
      case (st_q)
         TX_IDLE:
            if (start_resp || start_msg)
            begin
               st_d   = TX_HEAD;
               idx_d  = 3'h0;
               tcrc_d = CRC_INIT;
               if (start_resp && proto_q)
                  {tb_d, tlen_d} = {DONE_REV, rseq_q, CH_SOM, 3'h6};
               else if (start_resp)
                  {tb_d, tlen_d} = {8'h00, DONE_REV, CH_SOM, 3'h5};
               else if (proto_q)
                  {tb_d, tlen_d} = {24'h0, q_mem_q[rd_q], seqc, CH_SOM, 3'h3};
               else
                  {tb_d, tlen_d} = {32'h0, q_mem_q[rd_q], CH_SOM, 3'h2};
            end
         TX_HEAD:
            if (hs)
            begin
               idx_d = idx_q + 3'h1;
               if (idx_q == tlen_q - 3'h1)
               begin
                  st_d  = proto_q ? TX_CRC : TX_EOM;
                  idx_d = 3'h0;
               end
            end
         TX_CRC:
            if (hs)
            begin
               idx_d = idx_q + 3'h1;
               if (idx_q == 3'h3)
                  st_d = TX_EOM;
            end
         TX_EOM:
            if (hs)
               st_d = TX_IDLE;
         default:
            st_d = TX_IDLE;
      endcase
      mrdy_d = cnt_d != CW'(DEPTH);
      tx_d.valid = st_d != TX_IDLE;
      case (st_d)
         TX_HEAD: tx_d.data = tb_d[idx_d];
         TX_CRC:  tx_d.data = n2hex(tcrc_d[4'(15 - 4 * idx_d) -: 4]);
         TX_EOM:  tx_d.data = CH_EOM;
         default: tx_d.data = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q_mem_q <= '{default: 8'h00};
         {wr_q, rd_q, cnt_q, seq_q, wait_q, tmr_q} <= '0;
         {resp_q, rseq_q, cmd_q} <= '0;
         proto_q <= 1'b1;                                      // retransmitting after reset
         st_q    <= TX_IDLE;
         {tb_q, idx_q, tlen_q} <= '0;
         tcrc_q  <= CRC_INIT;
         tx_q    <= '0;
         mrdy_q  <= 1'b0;
      end
      else
      begin
         q_mem_q <= q_mem_d;
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         seq_q   <= seq_d;
         wait_q  <= wait_d;
         tmr_q   <= tmr_d;
         resp_q  <= resp_d;
         rseq_q  <= rseq_d;
         cmd_q   <= cmd_d;
         proto_q <= proto_d;
         st_q    <= st_d;
         tb_q    <= tb_d;
         idx_q   <= idx_d;
         tlen_q  <= tlen_d;
         tcrc_q  <= tcrc_d;
         tx_q    <= tx_d;
         mrdy_q  <= mrdy_d;
      end
   end

   assign tx                      = tx_q;
   assign msg_ready               = mrdy_q;
   assign cmd_mode                = cmd_q;
   assign ack_retransmit_protocol = proto_q;
   assign ack_wait                = wait_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_frame_open;
      tx.valid && tx.data == CH_SOM;
   endsequence
   sequence s_released;
      !ack_wait && tmr_q == $past(tmr_q);
   endsequence

   AST_RETX: assert property (start_msg && wait_q |=> s_frame_open ##0 tmr_q == 0)
      else $error("timed out message not sent again");
   AST_QUEUE: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 1)
      else $error("message not queued");
   AST_TIMER: assert property (wait_q && tmr_q < ACK_TIMEOUT && !ack_hit && !c610
      |=> tmr_q == $past(tmr_q) + 1)
      else $error("timeout counter stalled");
   AST_WILD: assert property (rx_eom && proto_q && rx_len_q == 4'h6 && wild && wait_q
      && rx_buf_q[1] == CH_ACK && rx_buf_q[0] == seqc |=> s_released)
      else $error("wildcard acknowledgement refused");
   AST_CMD01: assert property (c01 |=> cmd_mode && resp_q && rseq_q == $past(rx_buf_q[0]))
      else $error("command mode entry failed");
   AST_BASIC: assert property (c610 |=> !ack_retransmit_protocol && !ack_wait)
      else $error("basic protocol not selected");
   AST_ECP: assert property (c611 |=> ack_retransmit_protocol)
      else $error("retransmitting protocol not selected");
   AST_DATA: assert property (c00 |=> !cmd_mode ##1 !cmd_mode)
      else $error("data mode not resumed");
   AST_BADCRC: assert property (rx_eom && proto_q && !crc_ok |=> $stable(cmd_mode)
      && $stable(ack_wait))
      else $error("frame with bad crc acted on");
   AST_ACKHIT: assert property (ack_hit |=> s_released
      ##0 cnt_q + 1 == $past(cnt_q) + $past(push))
      else $error("acknowledged message not dropped");

endmodule // arml_link

// ===== src/arml_pkg.sv
// constants, carriers and states of the acknowledged message link
package arml_pkg;

   // characters of the frame
   localparam logic [7:0]  CH_SOM   = 8'h23;
   localparam logic [7:0]  CH_EOM   = 8'h0D;
   localparam logic [7:0]  CH_ACK   = 8'h40;
   localparam logic [7:0]  CH_WILD  = 8'h60;
   localparam logic [7:0]  CH_ZERO  = 8'h30;
   localparam logic [7:0]  CH_ONE   = 8'h31;
   localparam logic [7:0]  CH_SIX   = 8'h36;
   localparam logic [7:0]  CH_A     = 8'h41;
   localparam logic [7:0]  CH_LA    = 8'h61;
   localparam logic [31:0] DONE_REV = 32'h656E6F44;   // "Done", first char low

   // crc
   localparam logic [15:0] CRC_GENERATOR_POLYNOMIAL = 16'h1021;
   localparam logic [15:0] CRC_INIT                 = 16'h0000;

   // sizes
   localparam int RX_MAX      = 10;
   localparam int QUEUE_DEPTH = 8;
   localparam int SEQ_MOD     = 10;

   // timing
   localparam real     CLK_PERIOD_NS   = 4.0;
   localparam real     ACK_TIMEOUT_S   = 12.7;
   localparam longint  ACK_TIMEOUT_CYC = longint'(ACK_TIMEOUT_S * 1.0E9 / CLK_PERIOD_NS);

   // one byte of a stream
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } arml_byte_t;

   typedef enum {TX_IDLE, TX_HEAD, TX_CRC, TX_EOM} arml_tx_state_t;

endpackage

// ===== verification/ack_retransmit_message_link_bench.sv
// self-checking bench of the acknowledged message link
`timescale 1ns/100ps
module ack_retransmit_message_link_bench;
   import arml_pkg::*;
   localparam int TMO = 200;
   logic       clk;
   logic       resetn;
   logic       slow;
   logic       tx_ready;
   logic       msg_ready;
   logic       cmd_mode;
   logic       proto;
   logic       ack_wait;
   arml_byte_t rx;
   arml_byte_t tx;
   arml_byte_t msg;
   int         err_total;
   int         comparisons;
   logic [7:0] f[$];
   logic [7:0] e[$];

   // device under test with a short timeout and a small queue
   arml_link #(.DEPTH(4), .ACK_TIMEOUT(32'(TMO))) uut
   (
      .clk                     (clk),
      .resetn                  (resetn),
      .rx                      (rx),
      .tx                      (tx),
      .tx_ready                (tx_ready),
      .msg                     (msg),
      .msg_ready               (msg_ready),
      .cmd_mode                (cmd_mode),
      .ack_retransmit_protocol (proto),
      .ack_wait                (ack_wait)
   );

   // host on the far side
   arml_host host
   (
      .clk      (clk),
      .slow     (slow),
      .tx       (tx),
      .tx_ready (tx_ready),
      .rx       (rx)
   );

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input logic g, input logic x, input string what);
      comparisons++;
      if (g !== x)
      begin
         err_total++;
         $display("Error %0t: %s got %b want %b", $time, what, g, x);
      end
   endtask

   // compares the last frame taken against an expected one
   task automatic cmpf(input string what);
      bit bad;
      comparisons++;
      bad = f.size() != e.size();
      foreach (e[i])
         if (i >= f.size() || f[i] !== e[i])
            bad = 1'b1;
      if (bad)
      begin
         err_total++;
         $display("Error %0t: %s frame differs", $time, what);
      end
   endtask

   // waits for one whole device frame, bounded
   task automatic get_frame();
      int n = 0;
      while (host.eoms == 0 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 1000)
      begin
         err_total++;
         $display("Error %0t: frame missing", $time);
         summarize();
      end
      f = {};
      while (f.size() == 0 || f[$] !== CH_EOM)
         f.push_back(host.got.pop_front());
      host.eoms--;
   endtask

   // offers one message once the queue has room, then idles a cycle
   task automatic push(input logic [7:0] d);
      int n = 0;
      while (msg_ready !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 100)
      begin
         err_total++;
         $display("Error %0t: queue never opened", $time);
         summarize();
      end
      msg.valid = 1'b1;
      msg.data  = d;
      @(negedge clk);
      msg.valid = 1'b0;
      msg.data  = ~d;
      @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cmp(tx.valid, 1'b0, "tx idle");
      cmp(cmd_mode, 1'b0, "data mode");
      cmp(proto, 1'b1, "ack protocol");
      cmp(ack_wait, 1'b0, "no wait");
      cmp(msg_ready, 1'b1, "queue open");
      cmp(ACK_TIMEOUT_CYC == 64'd3175000000, 1'b1, "default timeout");
      $display("test reset done");
   endtask

   // resend of an unanswered frame with a stalling host, second message held
   task automatic t_retx();
      int gap;
      slow = 1'b1;
      push(CH_A);
      get_frame();
      host.mk({CH_ZERO, CH_A}, 1, 0, e);
      cmpf("first data");
      cmp(ack_wait, 1'b1, "waiting");
      push(CH_LA);
      get_frame();
      cmpf("resent data");
      gap = host.starts[1] - host.starts[0];
      cmp(gap >= TMO - 1 && gap <= TMO + 4, 1'b1, "resend time");
      slow = 1'b0;
      $display("test resend done");
   endtask

   // bad crc ack, foreign ack, wildcard ack, then a checked ack
   task automatic t_ack();
      host.send({CH_ZERO, CH_ACK, CH_ZERO, CH_ZERO, CH_ZERO, CH_ZERO}, 0, 0);
      repeat (4) @(negedge clk);
      cmp(ack_wait, 1'b1, "bad crc ignored");
      host.send({8'h37, CH_ACK}, 1, 1);
      repeat (4) @(negedge clk);
      cmp(ack_wait, 1'b1, "foreign ack ignored");
      host.send({CH_ZERO, CH_ACK}, 1, 1);
      get_frame();
      host.mk({CH_ONE, CH_LA}, 1, 0, e);
      cmpf("queued data");
      host.send({CH_ONE, CH_ACK}, 1, 0);
      repeat (4) @(negedge clk);
      cmp(ack_wait, 1'b0, "acknowledged");
      $display("test ack done");
   endtask

   // command mode, full queue, basic protocol, data mode again
   task automatic t_basic();
      host.send({8'h32, CH_ZERO, CH_ONE}, 1, 1);
      get_frame();
      host.mk({8'h32, 8'h44, 8'h6F, 8'h6E, 8'h65}, 1, 0, e);
      cmpf("done with sequence");
      cmp(cmd_mode, 1'b1, "command mode");
      for (int i = 0; i < 4; i++)
         push(CH_A + 8'(i));
      repeat (2) @(negedge clk);
      cmp(msg_ready, 1'b0, "queue full");
      host.send({8'h33, CH_SIX, CH_ONE, CH_ZERO}, 1, 1);
      get_frame();
      host.mk({8'h44, 8'h6F, 8'h6E, 8'h65}, 0, 0, e);
      cmpf("basic done");
      cmp(proto, 1'b0, "basic protocol");
      host.send({CH_ZERO, CH_ZERO}, 0, 0);
      get_frame();
      cmpf("basic done");
      cmp(cmd_mode, 1'b0, "data mode");
      for (int i = 0; i < 4; i++)
      begin
         get_frame();
         host.mk({CH_A + 8'(i)}, 0, 0, e);
         cmpf("basic data");
      end
      repeat (TMO + 50) @(negedge clk);
      cmp(host.eoms == 0, 1'b1, "no resend");
      cmp(ack_wait, 1'b0, "nothing waits");
      $display("test basic done");
   endtask

   // back to the acknowledged protocol, then data mode
   task automatic t_back();
      host.send({CH_ZERO, CH_ONE}, 0, 0);
      get_frame();
      cmp(cmd_mode, 1'b1, "command mode");
      host.send({CH_SIX, CH_ONE, CH_ONE}, 0, 0);
      get_frame();
      cmp(proto, 1'b1, "ack protocol");
      host.send({8'h35, CH_ZERO, CH_ZERO}, 1, 1);
      get_frame();
      host.mk({8'h35, 8'h44, 8'h6F, 8'h6E, 8'h65}, 1, 0, e);
      cmpf("ack done");
      cmp(cmd_mode, 1'b0, "data mode");
      $display("test return done");
   endtask

   // reset, then every scenario in turn
   initial
   begin
      resetn      = 1'b0;
      slow        = 1'b0;
      msg         = '0;
      err_total   = 0;
      comparisons = 0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      t_reset();
      t_retx();
      t_ack();
      t_basic();
      t_back();
      summarize();
   end
endmodule // ack_retransmit_message_link_bench

// ===== verification/arml_host.sv
// host side model of the serial port: sends frames, collects device frames
`timescale 1ns/100ps
module arml_host
(
   input  wire  logic                 clk,
   input  wire  logic                 slow,
   input  wire  arml_pkg::arml_byte_t tx,
   output logic                       tx_ready,
   output arml_pkg::arml_byte_t       rx
);
   import arml_pkg::*;
   logic [7:0] got[$];
   int         eoms;
   int         cyc;
   int         starts[$];

   // quiet line and ready host at time zero
   initial
   begin
      rx       = '0;
      tx_ready = 1'b1;
      eoms     = 0;
      cyc      = 0;
   end

   // stall every other cycle when slow, so the device must hold its byte
   always @(negedge clk)
   begin
      tx_ready <= !slow || !tx_ready;
   end

   // collect device bytes at each handshake, note frame starts and ends
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (tx.valid && tx_ready)
      begin
         got.push_back(tx.data);
         if (tx.data == CH_SOM)
            starts.push_back(cyc);
         if (tx.data == CH_EOM)
            eoms = eoms + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one hex digit, upper case
   function automatic logic [7:0] hex(input logic [3:0] v);
      return (v < 4'hA) ? CH_ZERO + 8'(v) : 8'h37 + 8'(v);
   endfunction

   // frame check value: zero start, bits shifted in msb first
   function automatic logic [15:0] crc(input logic [7:0] f[$]);
      logic [15:0] c;
      logic        m;
      c = 16'h0000;
      foreach (f[i])
         for (int k = 7; k >= 0; k--)
         begin
            m = c[15];
            c = {c[14:0], f[i][k]};
            if (m)
               c = c ^ 16'h1021;
         end
      return c;
   endfunction

   // wraps a body: start, body, four check digits or wildcards only when ack is set, end
   function automatic void mk(input logic [7:0] b[$], input bit ack, input bit wild,
                              output logic [7:0] f[$]);
      logic [15:0] c;
      f = {CH_SOM, b};
      c = crc(f);
      for (int n = 3; n >= 0; n--)
         if (ack)
            f.push_back(wild ? 8'h60 : hex(c[n*4 +: 4]));
      f.push_back(CH_EOM);
   endfunction

   // one byte per cycle from a falling edge; data inverts once idle
   task automatic send(input logic [7:0] b[$], input bit ack, input bit wild);
      logic [7:0] f[$];
      mk(b, ack, wild, f);
      foreach (f[i])
      begin
         rx.valid = 1'b1;
         rx.data  = f[i];
         @(negedge clk);
      end
      rx.valid = 1'b0;
      rx.data  = ~rx.data;
   endtask
endmodule // arml_host
